// >>> logic/cmf_dev.sv
// Transmit and receive message buffers of the controller
`timescale 1ns/1ns
module cmf_dev
  import cmf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  cmf_if.dev bus,
  input wire logic fd_en_in,
  input wire logic [TX_WAW-1:0] tx_idx_in,
  input wire logic tx_done_in,
  output logic tx_pend_out,
  output logic [31:0] tx_word_out,
  output logic [6:0] tx_len_out,
  output logic tx_fdf_out,
  output logic tx_brs_out,
  output logic tx_rtr_out,
  output logic tx_ide_out,
  output logic [10:0] tx_id_out,
  input wire logic rx_wr_in,
  input wire logic rx_sof_in,
  input wire logic [31:0] rx_wdata_in,
  output logic rx_drop_out,
  output logic [6:0] rx_used_out
);
  logic [7:0] tx_mem [0:TX_BYTES-1];
  logic [7:0] rx_mem [0:RX_BYTES-1];
  logic [TX_AW-1:0] tx_wptr_ff;
  logic tx_pend_ff;
  logic [31:0] tx_word_ff;
  logic [6:0] tx_len_ff;
  logic [3:0] tx_flag_ff;
  logic [10:0] tx_id_ff;
  logic [RX_AW-1:0] rx_rptr_ff;
  logic [RX_WAW-1:0] rx_wbase_ff;
  logic [RX_WAW-1:0] rx_wcur_ff;
  logic [4:0] rx_left_ff;
  logic [6:0] rx_used_ff;
  logic rx_drop_ff;
  logic [31:0] rdata_ff;
  logic rvalid_ff;
  logic [2:0] nb;
  logic tx_wr_ok;
  logic rx_rd_ok;
  logic [2:0] rd_end;
  logic [4:0] need;
  logic [6:0] free_words;
  logic rx_accept;
  logic rx_take;
  logic rx_commit;
  logic [6:0] commit_words;
  logic [RX_WAW-1:0] span;
  logic [6:0] hdr_bytes;
  logic [6:0] msg_bytes;
  logic [31:0] rx_weff;
  logic [31:0] nxt_rdata;
  logic [7:0] info;
  logic fdf_eff;
  logic [6:0] nxt_len;

  assign nb = cmf_size_bytes(bus.acc_size);
  // A pending message locks the buffer so the engine sees a stable frame
  assign tx_wr_ok = bus.acc_wr && !bus.tx_req && !tx_pend_ff;
  assign bus.tx_busy = tx_pend_ff;
  assign tx_pend_out = tx_pend_ff;

  // Transmit write pointer and pending flag
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_wptr_ff <= '0;
      tx_pend_ff <= 1'b0;
    end else if (tx_pend_ff && tx_done_in) begin
      tx_wptr_ff <= '0;
      tx_pend_ff <= 1'b0;
    end else if (!tx_pend_ff && bus.tx_req) begin
      tx_pend_ff <= 1'b1;
    end else if (tx_wr_ok) begin
      tx_wptr_ff <= tx_wptr_ff + TX_AW'(nb);
    end
  end

  // Each access moves its own width of bytes, starting at the port lane
  always_ff @(posedge sys_clk_in) begin
    for (int k = 0; k < 4; k++) begin
      if (tx_wr_ok && (3'(k) < nb)) begin
        tx_mem[tx_wptr_ff + TX_AW'(k)] <=
          cmf_lane(bus.acc_wdata, bus.acc_lane + 2'(k));
      end
    end
  end

  // Engine side view of the transmit buffer
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_word_ff <= '0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        tx_word_ff[8 * k +: 8] <= tx_mem[{tx_idx_in, 2'(k)}];
      end
    end
  end

  assign info = tx_mem[0];
  assign fdf_eff = info[FDF_BIT] && fd_en_in;

  always_comb begin
    nxt_len = cmf_dlc_bytes(info[DLC_LSB +: 4]);
    if (!fdf_eff) begin
      if (info[RTR_BIT]) begin
        nxt_len = 7'h00;
      end else if (nxt_len > CLASSIC_MAX) begin
        nxt_len = CLASSIC_MAX;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_len_ff <= '0;
      tx_flag_ff <= '0;
      tx_id_ff <= '0;
    end else begin
      tx_len_ff <= nxt_len;
      tx_flag_ff <= {info[IDE_BIT], info[RTR_BIT],
                     fdf_eff, info[BRS_BIT] && fdf_eff};
      tx_id_ff <= {tx_mem[1], tx_mem[2][7:5]};
    end
  end

  assign tx_word_out = tx_word_ff;
  assign tx_len_out = tx_len_ff;
  assign tx_ide_out = tx_flag_ff[3];
  assign tx_rtr_out = tx_flag_ff[2];
  assign tx_fdf_out = tx_flag_ff[1];
  assign tx_brs_out = tx_flag_ff[0];
  assign tx_id_out = tx_id_ff;

  // Receive side: whole messages only, packed word after word
  // Extended info adds two identifier bytes, the second of which spills into the next word
  assign hdr_bytes = rx_wdata_in[IDE_BIT] ? EXT_HDR_BYTES : HDR_BYTES;
  assign msg_bytes = hdr_bytes + cmf_dlc_bytes(rx_wdata_in[DLC_LSB +: 4]) +
                     7'h03;
  assign need = msg_bytes[6:2];
  assign free_words = 7'(RX_WORDS) - rx_used_ff;
  assign rx_accept = rx_wr_in && rx_sof_in && ({2'h0, need} <= free_words);
  assign rx_take = rx_accept || (rx_wr_in && !rx_sof_in && rx_left_ff != 0);
  assign rx_commit = (rx_accept && need == 5'h01) ||
                     (rx_wr_in && !rx_sof_in && rx_left_ff == 5'h01);
  // Span taken in pointer width so a message that wraps counts right
  assign span = rx_wcur_ff - rx_wbase_ff;
  assign commit_words = rx_accept ? 7'h01 : {1'b0, span} + 7'h01;
  // FDF and ESI flags forced low so software never sees them when FD is off; BRS passes through
  assign rx_weff = (rx_sof_in && !fd_en_in) ?
                   (rx_wdata_in & ~((32'h1 << FDF_BIT) |
                                    (32'h1 << ESI_BIT))) :
                   rx_wdata_in;

  always_ff @(posedge sys_clk_in) begin
    for (int k = 0; k < 4; k++) begin
      if (rx_take) begin
        rx_mem[{rx_accept ? rx_wbase_ff : rx_wcur_ff, 2'(k)}] <=
          rx_weff[8 * k +: 8];
      end
    end
  end

  // A new start abandons any unfinished message
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_wcur_ff <= '0;
      rx_left_ff <= '0;
      rx_drop_ff <= 1'b0;
    end else begin
      rx_drop_ff <= rx_wr_in && rx_sof_in && !rx_accept;
      if (rx_accept) begin
        rx_wcur_ff <= rx_wbase_ff + 1'b1;
        rx_left_ff <= need - 5'h01;
      end else if (rx_wr_in && rx_sof_in) begin
        rx_left_ff <= '0;
      end else if (rx_take) begin
        rx_wcur_ff <= rx_wcur_ff + 1'b1;
        rx_left_ff <= rx_left_ff - 5'h01;
      end
    end
  end

  assign rx_rd_ok = bus.acc_rd && (rx_used_ff != 0);
  assign rd_end = {1'b0, rx_rptr_ff[1:0]} + nb;
  assign bus.rx_empty = (rx_used_ff == 0);

  // Read pointer walks the queue in arrival order
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_rptr_ff <= '0;
      rx_wbase_ff <= '0;
      rx_used_ff <= '0;
    end else begin
      if (rx_rd_ok) begin
        rx_rptr_ff <= rx_rptr_ff + RX_AW'(nb);
      end
      if (rx_commit) begin
        rx_wbase_ff <= rx_wbase_ff + RX_WAW'(commit_words);
      end
      rx_used_ff <= rx_used_ff + (rx_commit ? commit_words : 7'h00) -
                    ((rx_rd_ok && rd_end[2]) ? 7'h01 : 7'h00);
    end
  end

  always_comb begin
    nxt_rdata = '0;
    for (int k = 0; k < 4; k++) begin
      if (rx_rd_ok && (3'(k) < nb)) begin
        nxt_rdata[8 * (bus.acc_lane + 2'(k)) +: 8] =
          rx_mem[rx_rptr_ff + RX_AW'(k)];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= bus.acc_rd;
    end
  end

  assign bus.acc_rdata = rdata_ff;
  assign bus.acc_rvalid = rvalid_ff;
  assign rx_drop_out = rx_drop_ff;
  assign rx_used_out = rx_used_ff;
endmodule : cmf_dev

// >>> logic/cmf_host.sv
// Processor side end that drives the buffer access ports
`timescale 1ns/1ns
module cmf_host
  import cmf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  cmf_if.host bus,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic cmd_txreq_in,
  input wire logic [1:0] cmd_size_in,
  input wire logic [1:0] cmd_port_in,
  input wire logic [31:0] cmd_wdata_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [31:0] rsp_data_out,
  output logic rx_empty_out,
  output logic tx_busy_out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ISSUE = 3'h2,
    ST_WAIT = 3'h4
  } cmf_state_t;

  cmf_state_t state_ff;
  cmf_state_t nxt_state;
  logic wr_ff;
  logic req_ff;
  logic [1:0] size_ff;
  logic [1:0] lane_ff;
  logic [31:0] wdata_ff;
  logic rsp_valid_ff;
  logic [31:0] rsp_data_ff;
  logic [1:0] nxt_lane;

  // Port index of a view becomes the byte lane of its first byte
  always_comb begin
    nxt_lane = cmd_port_in;
    if (cmd_size_in == SZ_WORD) begin
      nxt_lane = 2'h0;
    end else if (cmd_size_in == SZ_HALF) begin
      nxt_lane = {cmd_port_in[0], 1'b0};
    end
  end

  always_comb begin
    case (state_ff)
      ST_IDLE: nxt_state = cmd_valid_in ? ST_ISSUE : ST_IDLE;
      ST_ISSUE: nxt_state = (wr_ff || req_ff) ? ST_IDLE : ST_WAIT;
      ST_WAIT: nxt_state = bus.acc_rvalid ? ST_IDLE : ST_WAIT;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ff <= 1'b0;
      req_ff <= 1'b0;
      size_ff <= SZ_BYTE;
      lane_ff <= '0;
      wdata_ff <= '0;
    end else if (state_ff == ST_IDLE && cmd_valid_in) begin
      wr_ff <= cmd_write_in && !cmd_txreq_in;
      req_ff <= cmd_txreq_in;
      size_ff <= cmd_size_in;
      lane_ff <= nxt_lane;
      wdata_ff <= cmd_wdata_in;
    end
  end

  // Read data is returned right-aligned whatever lane it came in on
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= '0;
    end else begin
      rsp_valid_ff <= (state_ff == ST_WAIT) && bus.acc_rvalid;
      if ((state_ff == ST_WAIT) && bus.acc_rvalid) begin
        rsp_data_ff <= bus.acc_rdata >> (8 * lane_ff);
      end
    end
  end

  assign bus.acc_wr = (state_ff == ST_ISSUE) && wr_ff;
  assign bus.acc_rd = (state_ff == ST_ISSUE) && !wr_ff && !req_ff;
  assign bus.tx_req = (state_ff == ST_ISSUE) && req_ff;
  assign bus.acc_size = size_ff;
  assign bus.acc_lane = lane_ff;
  assign bus.acc_wdata = wdata_ff;
  assign cmd_ready_out = (state_ff == ST_IDLE);
  assign rsp_valid_out = rsp_valid_ff;
  assign rsp_data_out = rsp_data_ff;
  assign rx_empty_out = bus.rx_empty;
  assign tx_busy_out = bus.tx_busy;
endmodule : cmf_host

// >>> logic/cmf_if.sv
// Access port between processor side and message buffers
`timescale 1ns/1ns
interface cmf_if;
  logic acc_wr;
  logic acc_rd;
  logic [1:0] acc_size;
  logic [1:0] acc_lane;
  logic [31:0] acc_wdata;
  logic tx_req;
  logic [31:0] acc_rdata;
  logic acc_rvalid;
  logic rx_empty;
  logic tx_busy;

  modport dev (
    input acc_wr, acc_rd, acc_size, acc_lane, acc_wdata, tx_req,
    output acc_rdata, acc_rvalid, rx_empty, tx_busy
  );
  modport host (
    output acc_wr, acc_rd, acc_size, acc_lane, acc_wdata, tx_req,
    input acc_rdata, acc_rvalid, rx_empty, tx_busy
  );
endinterface : cmf_if

// >>> logic/cmf_pkg.sv
// Constants, field layout and helpers shared by both buffer ends
package cmf_pkg;
  localparam int TX_BYTES = 128;
  localparam int RX_BYTES = 256;
  localparam int TX_AW = 7;
  localparam int RX_AW = 8;
  localparam int RX_WORDS = RX_BYTES / 4;
  localparam int RX_WAW = RX_AW - 2;
  localparam int TX_WAW = TX_AW - 2;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam int DLC_LSB = 0;
  localparam int BRS_BIT = 4;
  localparam int FDF_BIT = 5;
  localparam int RTR_BIT = 6;
  localparam int IDE_BIT = 7;
  localparam int IDHI_LSB = 8;
  localparam int ESI_BIT = 20;
  localparam int IDLO_LSB = 21;
  localparam logic [6:0] HDR_BYTES = 7'h03;
  localparam logic [6:0] EXT_HDR_BYTES = 7'h05;
  localparam logic [6:0] CLASSIC_MAX = 7'h08;

  // Length code to payload byte count
  function automatic logic [6:0] cmf_dlc_bytes(input logic [3:0] dlc);
    logic [6:0] n;
    n = 7'h00;
    case (dlc)
      4'h9: n = 7'h0C;
      4'hA: n = 7'h10;
      4'hB: n = 7'h14;
      4'hC: n = 7'h18;
      4'hD: n = 7'h20;
      4'hE: n = 7'h30;
      4'hF: n = 7'h40;
      default: n = {3'h0, dlc};
    endcase
    return n;
  endfunction : cmf_dlc_bytes

  // Words one stored message without extended info takes: header bytes plus payload, rounded up
  function automatic logic [4:0] cmf_msg_words(input logic [3:0] dlc);
    logic [6:0] b;
    b = HDR_BYTES + cmf_dlc_bytes(dlc) + 7'h03;
    return b[6:2];
  endfunction : cmf_msg_words

  function automatic logic [2:0] cmf_size_bytes(input logic [1:0] sz);
    logic [2:0] n;
    n = 3'h1;
    if (sz == SZ_HALF) begin
      n = 3'h2;
    end else if (sz == SZ_WORD) begin
      n = 3'h4;
    end
    return n;
  endfunction : cmf_size_bytes

  function automatic logic [7:0] cmf_lane(input logic [31:0] w,
                                         input logic [1:0] idx);
    return w[8 * idx +: 8];
  endfunction : cmf_lane
endpackage : cmf_pkg

// >>> verif/cmf_props.sv
// Checker for the access ports between processor side and buffers
`timescale 1ns/1ns
module cmf_props
  import cmf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic acc_wr_in,
  input wire logic acc_rd_in,
  input wire logic [1:0] acc_size_in,
  input wire logic [1:0] acc_lane_in,
  input wire logic [31:0] acc_wdata_in,
  input wire logic tx_req_in,
  input wire logic [31:0] acc_rdata_in,
  input wire logic acc_rvalid_in,
  input wire logic rx_empty_in,
  input wire logic tx_busy_in
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  property p_rvalid;
    acc_rd_in |=> acc_rvalid_in;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  property p_rvalid_cause;
    acc_rvalid_in |-> $past(acc_rd_in);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("read answer without read");
  property p_busy;
    tx_req_in && !tx_busy_in |=> tx_busy_in;
  endproperty
  a_busy: assert property (p_busy) else $error("request not locked");
  property p_byte_lane;
    acc_rd_in && acc_size_in == SZ_BYTE |=>
      (acc_rdata_in & ~(32'h000000FF << {$past(acc_lane_in), 3'h0})) == 32'h0;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte lanes");
  property p_half_lane;
    acc_rd_in && acc_size_in == SZ_HALF |=>
      (acc_rdata_in & ~(32'h0000FFFF << {$past(acc_lane_in), 3'h0})) == 32'h0;
  endproperty
  a_half_lane: assert property (p_half_lane) else $error("half lanes");
  property p_empty_zero;
    acc_rd_in && rx_empty_in |=> acc_rdata_in == 32'h0;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty read");
  property p_rd_one;
    acc_rd_in |=> !acc_rd_in;
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("read strobe held");
  property p_wr_one;
    acc_wr_in |=> !acc_wr_in;
  endproperty
  a_wr_one: assert property (p_wr_one) else $error("write strobe held");
  property p_size;
    acc_wr_in || acc_rd_in |-> acc_size_in != 2'h3;
  endproperty
  a_size: assert property (p_size) else $error("bad access size");
  property p_word_lane;
    (acc_wr_in || acc_rd_in) && acc_size_in == SZ_WORD |->
      acc_lane_in == 2'h0;
  endproperty
  a_word_lane: assert property (p_word_lane) else $error("word lane");
  property p_wdata_hold;
    acc_wr_in |=> $stable(acc_wdata_in);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold)
    else $error("write data moved");
  property p_rdata_idle;
    !acc_rd_in |=> acc_rdata_in == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared");
endmodule : cmf_props

// >>> verif/tb_can_message_fifo_interface.sv
// Testbench joining both buffer ends through their access interface
`timescale 1ns/1ns
module tb_can_message_fifo_interface
  import cmf_pkg::*;
;
  logic sys_clk, resetn, fd_en, tx_done, rx_wr, rx_sof, rx_drop;
  logic cmd_valid, cmd_write, cmd_txreq, cmd_ready, rsp_valid;
  logic tx_pend, tx_fdf, tx_brs, tx_rtr, tx_ide, rx_empty_o, tx_busy_o;
  logic [1:0] cmd_size, cmd_port;
  logic [TX_WAW-1:0] tx_idx;
  logic [31:0] rx_wdata, cmd_wdata, rsp_data, tx_word, rd_val;
  logic [6:0] tx_len, rx_used;
  logic [10:0] tx_id;
  logic [31:0] msg [0:16];
  logic dropped;
  int bad_count, checks_done, cnt, wds;
  int nbytes [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 16, 20, 24, 32, 48, 64};
  int caps [16] = '{64, 64, 32, 32, 32, 32, 21, 21, 21, 16, 12, 10, 9, 7,
                    4, 3};
  int ecaps [16] = '{32, 32, 32, 32, 21, 21, 21, 21, 16, 12, 10, 9, 8, 6,
                     4, 3};
  logic [31:0] infos [3] = '{32'h1170B43F, 32'h1170B43F, 32'h1170B448};
  logic fds [3] = '{1'b1, 1'b0, 1'b1};
  int lens [3] = '{64, 8, 0};
  logic [31:0] twd [3];
  logic [7:0] b3 [3] = '{8'h50, 8'h12, 8'h24};

  cmf_if bus_if ();
  cmf_dev cmf_dev_inst (.sys_clk_in(sys_clk), .resetn_in(resetn),
    .bus(bus_if), .fd_en_in(fd_en), .tx_idx_in(tx_idx),
    .tx_done_in(tx_done), .tx_pend_out(tx_pend), .tx_word_out(tx_word),
    .tx_len_out(tx_len), .tx_fdf_out(tx_fdf), .tx_brs_out(tx_brs),
    .tx_rtr_out(tx_rtr), .tx_ide_out(tx_ide), .tx_id_out(tx_id),
    .rx_wr_in(rx_wr), .rx_sof_in(rx_sof), .rx_wdata_in(rx_wdata),
    .rx_drop_out(rx_drop), .rx_used_out(rx_used));
  cmf_host cmf_host_inst (.sys_clk_in(sys_clk), .resetn_in(resetn),
    .bus(bus_if), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
    .cmd_txreq_in(cmd_txreq), .cmd_size_in(cmd_size),
    .cmd_port_in(cmd_port), .cmd_wdata_in(cmd_wdata),
    .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .rx_empty_out(rx_empty_o),
    .tx_busy_out(tx_busy_o));
  cmf_props cmf_props_inst (.sys_clk_in(sys_clk), .resetn_in(resetn),
    .acc_wr_in(bus_if.acc_wr), .acc_rd_in(bus_if.acc_rd),
    .acc_size_in(bus_if.acc_size), .acc_lane_in(bus_if.acc_lane),
    .acc_wdata_in(bus_if.acc_wdata), .tx_req_in(bus_if.tx_req),
    .acc_rdata_in(bus_if.acc_rdata), .acc_rvalid_in(bus_if.acc_rvalid),
    .rx_empty_in(bus_if.rx_empty), .tx_busy_in(bus_if.tx_busy));

  always #20 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // One host command; reads leave their answer in rd_val
  task automatic op(input logic w, input logic t, input logic [1:0] sz,
                    input logic [1:0] pt, input logic [31:0] wd);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_txreq = t;
    cmd_size = sz;
    cmd_port = pt;
    cmd_wdata = wd;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (!w && !t && rsp_valid !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (!w && !t) check(rsp_valid, 1'b1);
    rd_val = rsp_data;
  endtask : op

  // Strobe stays high across words so no edge sees a released strobe
  task automatic rx_msg(input int n);
    for (int i = 0; i < n; i++) begin
      rx_wr = 1'b1;
      rx_sof = (i == 0);
      rx_wdata = msg[i];
      @(posedge sys_clk);
      #1;
      if (rx_drop === 1'b1) dropped = 1'b1;
    end
    rx_wr = 1'b0;
    rx_sof = 1'b0;
    @(posedge sys_clk);
    #1;
    if (rx_drop === 1'b1) dropped = 1'b1;
  endtask : rx_msg

  initial begin
    #(40 * 20000);
    bad_count++;
    conclude();
  end

  initial begin
    {sys_clk, resetn, fd_en, tx_done, rx_wr, rx_sof, cmd_valid} = 7'h00;
    {cmd_write, cmd_txreq, cmd_size, cmd_port, tx_idx} = 11'h000;
    {rx_wdata, cmd_wdata} = 64'h0;
    for (int i = 0; i < 17; i++) msg[i] = 32'hC0DE0000 + i;
    repeat (20) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    check(rx_empty_o, 1'b1);
    check(tx_busy_o, 1'b0);
    check(cmd_ready, 1'b1);
    $display("test reset done");
    fd_en = 1'b1;
    msg[0] = 32'h1170B435;
    msg[1] = 32'h55443322;
    rx_msg(2);
    check(rx_used, 7'h02);
    op(1'b0, 1'b0, SZ_WORD, 2'h0, 32'h0);
    check(rd_val, 32'h1170B435);
    op(1'b0, 1'b0, SZ_HALF, 2'h0, 32'h0);
    check(rd_val, 32'h00003322);
    op(1'b0, 1'b0, SZ_HALF, 2'h1, 32'h0);
    check(rd_val, 32'h00005544);
    check(rx_empty_o, 1'b1);
    op(1'b0, 1'b0, SZ_BYTE, 2'h0, 32'h0);
    check(rd_val, 32'h0);
    $display("test receive layout done");
    fd_en = 1'b0;
    msg[0] = 32'hAB341270;
    rx_msg(1);
    for (int i = 0; i < 4; i++) begin
      op(1'b0, 1'b0, SZ_BYTE, i[1:0], 32'h0);
      if (i < 3) check(rd_val, {24'h0, b3[i]});
    end
    $display("test receive flags done");
    for (int e = 0; e < 2; e++) begin
      for (int d = 0; d < 16; d++) begin
        resetn = 1'b0;
        @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        msg[0] = d + (e << IDE_BIT);
        wds = (3 + 2 * e + nbytes[d] + 3) / 4;
        cnt = 0;
        dropped = 1'b0;
        while (!dropped && cnt < 70) begin
          rx_msg(wds);
          if (!dropped) cnt++;
        end
        check(cnt, (e == 1) ? ecaps[d] : caps[d]);
        check(rx_used, cnt * wds);
      end
    end
    $display("test receive capacity done");
    for (int c = 0; c < 3; c++) begin
      fd_en = fds[c];
      twd = '{infos[c], 32'h55443322, 32'h99887766};
      op(1'b1, 1'b0, SZ_WORD, 2'h0, infos[c]);
      op(1'b1, 1'b0, SZ_HALF, 2'h0, 32'h00003322);
      op(1'b1, 1'b0, SZ_HALF, 2'h1, 32'h55440000);
      for (int b = 0; b < 4; b++) begin
        op(1'b1, 1'b0, SZ_BYTE, b[1:0], 32'h99887766 & (32'hFF << 8 * b));
      end
      op(1'b0, 1'b1, 2'h0, 2'h0, 32'h0);
      repeat (2) @(posedge sys_clk);
      #1;
      check(tx_busy_o, 1'b1);
      check(tx_pend, 1'b1);
      op(1'b1, 1'b0, SZ_WORD, 2'h0, 32'hFFFFFFFF);
      for (int w = 0; w < 3; w++) begin
        tx_idx = w[TX_WAW-1:0];
        @(posedge sys_clk);
        #1;
        check(tx_word, twd[w]);
      end
      check(tx_len, lens[c]);
      check(tx_rtr, c == 2);
      check(tx_fdf, c == 0);
      check(tx_brs, c == 0);
      check(tx_ide, 1'b0);
      check(tx_id, 11'h5A3);
      tx_done = 1'b1;
      @(posedge sys_clk);
      #1;
      tx_done = 1'b0;
      @(posedge sys_clk);
      #1;
      check(tx_busy_o, 1'b0);
      check(tx_pend, 1'b0);
    end
    $display("test transmit done");
    conclude();
  end
endmodule : tb_can_message_fifo_interface
